// ### src/power_supervisor_pkg.sv
package power_supervisor_pkg;

  // ==========================================================
  // serial register map
  localparam logic [7:0] REG_EXT_BANK = 8'h1a;
  localparam logic [7:0] REG_UNLOCK = 8'h1c;
  localparam logic [7:0] REG_SYSTEM = 8'h20;
  localparam logic [7:0] REG_SUPERVISOR = 8'h21;
  localparam logic [7:0] REG_WAKE_TIME = 8'h22;
  localparam logic [7:0] REG_RAIL_EN0 = 8'h23;
  localparam logic [7:0] REG_RAIL_EN1 = 8'h24;
  localparam logic [2:0] SUB_OUT_CTRL = 3'h1;
  localparam logic [2:0] SUB_HBT_SEL = 3'h4;
  localparam logic [7:0] SYS_SHUTDOWN = 8'h00;
  localparam logic [7:0] SYS_WATCHDOG = 8'h03;
  localparam logic [7:0] SYS_HEARTBEAT = 8'h09;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] WAKE_BYTES = 2'h3;

  // ==========================================================
  // field positions
  localparam int SYS_TEMP_OFF_BIT = 2;
  localparam int SUP_SHORT_HOLD_BIT = 7;
  localparam int SUP_ANALOG_OFF_BIT = 6;
  localparam int SUP_TEMP_LSB = 0;
  localparam int RAIL0_PR1_BIT = 1;
  localparam int RAIL0_PR2_BIT = 3;
  localparam int RAIL0_CORE1_BIT = 7;
  localparam int RAIL1_CORE2_BIT = 1;
  localparam int HBT_SEL_LSB = 2;
  localparam int OUT_PG_LSB = 0;
  localparam int OUT_RST_LSB = 2;
  // 140 degC
  localparam logic [7:0] TEMP_LIMIT = 8'h8c;

  // ==========================================================
  // pin drive modes
  localparam logic [1:0] PIN_PP_WEAK = 2'h0;
  localparam logic [1:0] PIN_PP_STRONG = 2'h1;
  localparam logic [1:0] PIN_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] PIN_TRISTATE = 2'h3;

  // ==========================================================
  // timing, counted in 1 us ticks
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int RAIL_LOW_US = 680;
  // strictly longer than the limit
  localparam int RAIL_LOW_TICKS = RAIL_LOW_US * 1000 / TICK_NS + 1;
  localparam int KEY_HOLD_LONG_S = 10;
  localparam int KEY_HOLD_SHORT_S = 5;
  localparam int ALIVE_TIMEOUT_MS = 500;
  localparam int KEY_HOLD_LONG_TICKS = KEY_HOLD_LONG_S * (1000000000 / TICK_NS);
  localparam int KEY_HOLD_SHORT_TICKS = KEY_HOLD_SHORT_S * (1000000000 / TICK_NS);
  localparam int ALIVE_TIMEOUT_TICKS = ALIVE_TIMEOUT_MS * (1000000 / TICK_NS);
  typedef logic [23:0] timer_count_t;
  typedef logic [5:0] tick_count_t;
  localparam int N_TIMERS = 8;
  localparam int T_ANALOG = 0;
  localparam int T_PR1 = 1;
  localparam int T_PR2 = 2;
  localparam int T_CORE1 = 3;
  localparam int T_CORE2 = 4;
  localparam int T_KEY = 5;
  localparam int T_HBT = 6;
  localparam int T_WDOG = 7;

  // ==========================================================
  // host AXI4-Lite map
  localparam logic [7:0] AXI_CMD = 8'h00;
  localparam logic [7:0] AXI_STATUS = 8'h04;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_ADDR_LSB = 8;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### src/supervisor_link.sv
`timescale 1ns/1ps
interface supervisor_link;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport device (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// ### src/held_condition_timer.sv
`timescale 1ns/1ps
module held_condition_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // condition
  input wire logic tick,
  input wire logic cond,
  input wire power_supervisor_pkg::timer_count_t limit,
  output logic fired
);
  power_supervisor_pkg::timer_count_t count;
  power_supervisor_pkg::timer_count_t next_count;

  // ==========================================================
  // counting
  always_comb
  begin
    next_count = count;
    if (!cond)
      next_count = '0;
    else if (tick && count != limit)
      next_count = count + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else
      count <= next_count;
  end

  assign fired = cond && count == limit;
endmodule

// ### src/power_up_down_supervisor.sv
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module power_up_down_supervisor #(
  parameter int KEY_HOLD_LONG_TICKS = power_supervisor_pkg::KEY_HOLD_LONG_TICKS,
  parameter int KEY_HOLD_SHORT_TICKS = power_supervisor_pkg::KEY_HOLD_SHORT_TICKS,
  parameter int ALIVE_TIMEOUT_TICKS = power_supervisor_pkg::ALIVE_TIMEOUT_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control link
  supervisor_link.device link,
  // wake sources
  input wire logic power_key_input,
  input wire logic alt_key_input,
  input wire logic charger_input_pin,
  input wire logic usb_bus_present,
  input wire logic rtc_second_tick,
  // supervision
  input wire logic [2:0] heartbeat_input,
  input wire logic [7:0] junction_temp,
  input wire logic [4:0] rail_low,
  // output pins
  output logic power_good_output_out,
  output logic power_good_output_oe,
  output logic power_good_output_strong,
  output logic system_reset_output_n_out,
  output logic system_reset_output_oe,
  output logic system_reset_output_strong,
  output logic system_powered
);
  typedef enum logic {st_off, st_on} power_state_t;

  function automatic logic [2:0] pin_drive(input logic [1:0] mode, input logic level);
    case (mode)
      power_supervisor_pkg::PIN_PP_WEAK: pin_drive = {level, 1'b1, 1'b0};
      power_supervisor_pkg::PIN_PP_STRONG: pin_drive = {level, 1'b1, 1'b1};
      power_supervisor_pkg::PIN_OPEN_DRAIN: pin_drive = {1'b0, !level, 1'b0};
      default: pin_drive = 3'h0;
    endcase
  endfunction

  power_state_t state, next_state;
  logic ack, next_ack;
  logic [7:0] rdata, next_rdata;
  logic [7:0] unlock, next_unlock, out_ctrl, next_out_ctrl, hbt_sel, next_hbt_sel;
  logic [7:0] sys, next_sys, sup, next_sup, rail_en0, next_rail_en0, rail_en1, next_rail_en1;
  logic [23:0] wake_time, next_wake_time;
  logic [1:0] wake_ptr, next_wake_ptr;
  logic wake_armed, next_wake_armed;
  logic [4:0] prev, next_prev;
  power_supervisor_pkg::tick_count_t tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  localparam int N_T = power_supervisor_pkg::N_TIMERS;
  logic [5:0] pins, next_pins;
  logic [N_T-1:0] timer_cond, timer_fired;
  power_supervisor_pkg::timer_count_t limits [N_T];

  logic access, wr_sys, cmd_shutdown, shutdown_req, wake_fire, power_up_req, temp_hot, hbt_seen, hbt_level;
  logic [1:0] hbt_src;
  logic [7:0] temp_limit;

  assign access = link.req && !ack;
  assign wr_sys = access && link.we && link.addr == power_supervisor_pkg::REG_SYSTEM;
  assign hbt_src = hbt_sel[power_supervisor_pkg::HBT_SEL_LSB +: 2];
  // heartbeat command with no source is the timed-wake power-down
  assign cmd_shutdown = wr_sys && (link.wdata == power_supervisor_pkg::SYS_SHUTDOWN
    || (link.wdata == power_supervisor_pkg::SYS_HEARTBEAT && hbt_src == 2'h0));
  assign temp_limit = power_supervisor_pkg::TEMP_LIMIT - {3'h0, sup[power_supervisor_pkg::SUP_TEMP_LSB +: 5]};
  assign temp_hot = junction_temp >= temp_limit && !sys[power_supervisor_pkg::SYS_TEMP_OFF_BIT];
  assign shutdown_req = state == st_on && (cmd_shutdown || |timer_fired || temp_hot);
  assign wake_fire = wake_armed && wake_time == 24'h0;
  assign hbt_level = hbt_src == 2'h0 ? 1'b0 : heartbeat_input[hbt_src - 2'h1];
  assign hbt_seen = hbt_level != prev[4];
  assign power_up_req = (power_key_input && !prev[0])
    || (charger_input_pin && !prev[1])
    || (usb_bus_present && !prev[2])
    || (alt_key_input && !prev[3])
    || wake_fire;

  // ==========================================================
  // link and registers
  always_comb
  begin
    next_ack = access;
    next_rdata = rdata;
    next_unlock = unlock;
    next_out_ctrl = out_ctrl;
    next_hbt_sel = hbt_sel;
    next_sys = sys;
    next_sup = sup;
    next_rail_en0 = rail_en0;
    next_rail_en1 = rail_en1;
    next_wake_time = wake_time;
    next_wake_ptr = wake_ptr;
    next_wake_armed = wake_armed;
    if (wake_armed && rtc_second_tick && wake_time != 24'h0)
      next_wake_time = wake_time - 24'h1;
    if (wake_fire && state == st_off)
      next_wake_armed = 1'b0;
    if (access && link.we)
    begin
      case (link.addr)
        power_supervisor_pkg::REG_UNLOCK: next_unlock = link.wdata;
        power_supervisor_pkg::REG_EXT_BANK:
        begin
          if (unlock[2:0] == power_supervisor_pkg::SUB_OUT_CTRL)
            next_out_ctrl = link.wdata;
          else if (unlock[2:0] == power_supervisor_pkg::SUB_HBT_SEL)
            next_hbt_sel = link.wdata;
        end
        power_supervisor_pkg::REG_SYSTEM: next_sys = link.wdata;
        power_supervisor_pkg::REG_SUPERVISOR: next_sup = link.wdata;
        power_supervisor_pkg::REG_WAKE_TIME:
        begin
          next_wake_time = {wake_time[15:0], link.wdata};
          if (wake_ptr != power_supervisor_pkg::WAKE_BYTES)
            next_wake_ptr = wake_ptr + 2'h1;
        end
        power_supervisor_pkg::REG_RAIL_EN0: next_rail_en0 = link.wdata;
        power_supervisor_pkg::REG_RAIL_EN1: next_rail_en1 = link.wdata;
        default: next_rdata = rdata;
      endcase
    end
    else if (access)
    begin
      case (link.addr)
        power_supervisor_pkg::REG_UNLOCK: next_rdata = unlock;
        power_supervisor_pkg::REG_EXT_BANK:
          next_rdata = unlock[2:0] == power_supervisor_pkg::SUB_OUT_CTRL ? out_ctrl : hbt_sel;
        power_supervisor_pkg::REG_SYSTEM: next_rdata = sys;
        power_supervisor_pkg::REG_SUPERVISOR: next_rdata = sup;
        power_supervisor_pkg::REG_WAKE_TIME: next_rdata = wake_time[7:0];
        power_supervisor_pkg::REG_RAIL_EN0: next_rdata = rail_en0;
        power_supervisor_pkg::REG_RAIL_EN1: next_rdata = rail_en1;
        default: next_rdata = 8'h00;
      endcase
    end
    if (wr_sys && link.wdata == power_supervisor_pkg::SYS_HEARTBEAT && hbt_src == 2'h0
      && wake_ptr == power_supervisor_pkg::WAKE_BYTES)
    begin
      next_wake_armed = 1'b1;
      next_wake_ptr = 2'h0;
    end
    if (wr_sys && link.wdata == power_supervisor_pkg::SYS_SHUTDOWN)
    begin
      next_wake_armed = 1'b0;
      next_wake_ptr = 2'h0;
    end
    // watchdog and heartbeat are re-armed by software after every power-up
    if (shutdown_req)
      next_sys = power_supervisor_pkg::SYS_SHUTDOWN;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack <= 1'b0;
      rdata <= 8'h00;
      unlock <= power_supervisor_pkg::REG_RESET;
      out_ctrl <= power_supervisor_pkg::REG_RESET;
      hbt_sel <= power_supervisor_pkg::REG_RESET;
      sys <= power_supervisor_pkg::REG_RESET;
      sup <= power_supervisor_pkg::REG_RESET;
      rail_en0 <= power_supervisor_pkg::REG_RESET;
      rail_en1 <= power_supervisor_pkg::REG_RESET;
      wake_time <= 24'h0;
      wake_ptr <= 2'h0;
      wake_armed <= 1'b0;
    end
    else
    begin
      ack <= next_ack;
      rdata <= next_rdata;
      unlock <= next_unlock;
      out_ctrl <= next_out_ctrl;
      hbt_sel <= next_hbt_sel;
      sys <= next_sys;
      sup <= next_sup;
      rail_en0 <= next_rail_en0;
      rail_en1 <= next_rail_en1;
      wake_time <= next_wake_time;
      wake_ptr <= next_wake_ptr;
      wake_armed <= next_wake_armed;
    end
  end
  assign link.ack = ack;
  assign link.rdata = rdata;

  // ==========================================================
  // timed conditions
  always_comb
  begin
    timer_cond = '0;
    timer_cond[power_supervisor_pkg::T_ANALOG] = rail_low[0] && !sup[power_supervisor_pkg::SUP_ANALOG_OFF_BIT];
    timer_cond[power_supervisor_pkg::T_PR1] = rail_low[1] && rail_en0[power_supervisor_pkg::RAIL0_PR1_BIT];
    timer_cond[power_supervisor_pkg::T_PR2] = rail_low[2] && rail_en0[power_supervisor_pkg::RAIL0_PR2_BIT];
    timer_cond[power_supervisor_pkg::T_CORE1] = rail_low[3] && rail_en0[power_supervisor_pkg::RAIL0_CORE1_BIT];
    timer_cond[power_supervisor_pkg::T_CORE2] = rail_low[4] && rail_en1[power_supervisor_pkg::RAIL1_CORE2_BIT];
    timer_cond[power_supervisor_pkg::T_KEY] = power_key_input;
    timer_cond[power_supervisor_pkg::T_HBT] = sys == power_supervisor_pkg::SYS_HEARTBEAT
      && hbt_src != 2'h0 && !hbt_seen;
    timer_cond[power_supervisor_pkg::T_WDOG] = sys == power_supervisor_pkg::SYS_WATCHDOG
      && !(access && !link.we);
    if (state != st_on)
      timer_cond = '0;
    for (int i = 0; i < power_supervisor_pkg::T_KEY; i++)
      limits[i] = power_supervisor_pkg::timer_count_t'(power_supervisor_pkg::RAIL_LOW_TICKS);
    limits[power_supervisor_pkg::T_KEY] = sup[power_supervisor_pkg::SUP_SHORT_HOLD_BIT]
      ? power_supervisor_pkg::timer_count_t'(KEY_HOLD_SHORT_TICKS)
      : power_supervisor_pkg::timer_count_t'(KEY_HOLD_LONG_TICKS);
    limits[power_supervisor_pkg::T_HBT] = power_supervisor_pkg::timer_count_t'(ALIVE_TIMEOUT_TICKS);
    limits[power_supervisor_pkg::T_WDOG] = power_supervisor_pkg::timer_count_t'(ALIVE_TIMEOUT_TICKS);
  end

  for (genvar g = 0; g < N_T; g++)
  begin : g_timer
    held_condition_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .cond(timer_cond[g]),
      .limit(limits[g]),
      .fired(timer_fired[g])
    );
  end

  // ==========================================================
  // power state, tick divider, edges and pins
  always_comb
  begin
    next_state = state;
    case (state)
      st_off: if (power_up_req) next_state = st_on;
      st_on: if (shutdown_req) next_state = st_off;
      default: next_state = st_off;
    endcase
    next_tick = tick_cnt == power_supervisor_pkg::tick_count_t'(power_supervisor_pkg::TICK_CYCLES - 1);
    next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
    next_prev = {hbt_level, alt_key_input, usb_bus_present, charger_input_pin, power_key_input};
    next_pins = {pin_drive(out_ctrl[power_supervisor_pkg::OUT_PG_LSB +: 2], next_state == st_on),
      pin_drive(out_ctrl[power_supervisor_pkg::OUT_RST_LSB +: 2], next_state == st_on)};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= st_off;
      tick <= 1'b0;
      tick_cnt <= '0;
      prev <= 5'h00;
      pins <= 6'h00;
    end
    else
    begin
      state <= next_state;
      tick <= next_tick;
      tick_cnt <= next_tick_cnt;
      prev <= next_prev;
      pins <= next_pins;
    end
  end
  assign {power_good_output_out, power_good_output_oe, power_good_output_strong} = pins[5:3];
  assign {system_reset_output_n_out, system_reset_output_oe, system_reset_output_strong} = pins[2:0];
  assign system_powered = state == st_on;
endmodule

// ### src/supervisor_host.sv
`timescale 1ns/1ps
module supervisor_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // control link
  supervisor_link.host link
);
  function automatic logic is_reg(input logic [31:0] a, input logic [7:0] off);
    is_reg = a == {24'h0, off};
  endfunction

  logic aw_ok, next_aw_ok, w_ok, next_w_ok, awready, next_awready, wready, next_wready;
  logic [31:0] awaddr, next_awaddr, wdata, next_wdata, rdata_q, next_rdata_q;
  logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic req, next_req, we, next_we;
  logic [7:0] addr, next_addr, wd, next_wd, last, next_last;

  // ==========================================================
  // bus slave and link master
  always_comb
  begin
    next_aw_ok = aw_ok;
    next_w_ok = w_ok;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata_q = rdata_q;
    next_req = req;
    next_we = we;
    next_addr = addr;
    next_wd = wd;
    next_last = last;
    if (req && link.ack)
    begin
      next_req = 1'b0;
      next_last = link.rdata;
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_awvalid && awready)
    begin
      next_aw_ok = 1'b1;
      next_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready)
    begin
      next_w_ok = 1'b1;
      for (int i = 0; i < 4; i++)
        next_wdata[8*i +: 8] = s_axi_wstrb[i] ? s_axi_wdata[8*i +: 8] : 8'h00;
    end
    if (aw_ok && w_ok && !bvalid)
    begin
      next_aw_ok = 1'b0;
      next_w_ok = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_reg(awaddr, power_supervisor_pkg::AXI_CMD) || is_reg(awaddr, power_supervisor_pkg::AXI_STATUS)
        ? power_supervisor_pkg::RESP_OKAY : power_supervisor_pkg::RESP_SLVERR;
      // a command while the link is busy is dropped
      if (is_reg(awaddr, power_supervisor_pkg::AXI_CMD) && !req)
      begin
        next_req = 1'b1;
        next_we = wdata[power_supervisor_pkg::CMD_WRITE_BIT];
        next_addr = wdata[power_supervisor_pkg::CMD_ADDR_LSB +: 8];
        next_wd = wdata[7:0];
      end
    end
    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = power_supervisor_pkg::RESP_OKAY;
      next_rdata_q = 32'h0;
      if (is_reg(s_axi_araddr, power_supervisor_pkg::AXI_STATUS))
        next_rdata_q = {16'h0, last, 7'h0, req};
      else if (is_reg(s_axi_araddr, power_supervisor_pkg::AXI_CMD))
        next_rdata_q = {15'h0, we, addr, wd};
      else
        next_rresp = power_supervisor_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_ok && !next_bvalid;
    next_wready = !next_w_ok && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awaddr <= 32'h0;
      wdata <= 32'h0;
      bvalid <= 1'b0;
      bresp <= power_supervisor_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= power_supervisor_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
      req <= 1'b0;
      we <= 1'b0;
      addr <= 8'h00;
      wd <= 8'h00;
      last <= 8'h00;
    end
    else
    begin
      aw_ok <= next_aw_ok;
      w_ok <= next_w_ok;
      awready <= next_awready;
      wready <= next_wready;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata_q <= next_rdata_q;
      req <= next_req;
      we <= next_we;
      addr <= next_addr;
      wd <= next_wd;
      last <= next_last;
    end
  end
  assign s_axi_awready = awready;
  assign s_axi_wready = wready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata_q;
  assign link.req = req;
  assign link.we = we;
  assign link.addr = addr;
  assign link.wdata = wd;
endmodule

// ### verification/supervisor_link_monitor.sv
`timescale 1ns/1ps
module supervisor_link_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  // ============
  // link handshake
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ack_one_cycle_a: assert property (req && !ack |=> ack) else $error("ack late");
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
  req_held_a: assert property (req && !ack |=> req && $stable({we, addr, wdata})) else $error("request moved");
  req_release_a: assert property (ack |=> !req) else $error("request kept");
  ack_cause_a: assert property (ack |-> $past(req) && !$past(ack)) else $error("stray ack");
  rdata_hold_a: assert property ($changed(rdata) |-> ack && !we) else $error("read data moved");
  req_drop_a: assert property ($fell(req) |-> $past(ack)) else $error("request withdrawn");
  ack_idle_a: assert property (!req |=> !ack) else $error("ack unasked");
  cover property (ack && we && addr == 8'h22);
  cover property (ack && !we);
  cover property (ack ##2 req);
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  // ============
  // pins
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, src_pins = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, x, y;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic power_key_input, alt_key_input, charger_input_pin, usb_bus_present, rtc_second_tick = 1'h0;
  logic [2:0] heartbeat_input = 3'h0;
  logic [7:0] junction_temp = 8'h19;
  logic [4:0] rail_low = 5'h0;
  logic power_good_output_out, power_good_output_oe, power_good_output_strong, system_powered;
  logic system_reset_output_n_out, system_reset_output_oe, system_reset_output_strong;
  int n_errors = 0;
  int n_tests = 0;
  assign {alt_key_input, usb_bus_present, charger_input_pin, power_key_input} = src_pins;
  supervisor_link lnk ();
  // short counts keep the run brief
  power_up_down_supervisor #(.KEY_HOLD_LONG_TICKS(20), .KEY_HOLD_SHORT_TICKS(10), .ALIVE_TIMEOUT_TICKS(10))
    i_power_up_down_supervisor (.link(lnk), .*);
  supervisor_host i_supervisor_host (.link(lnk), .*);
  supervisor_link_monitor i_supervisor_link_monitor (.aclk(aclk), .aresetn(aresetn), .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
  initial forever #10 aclk = ~aclk;
  // ============
  // helpers
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) n_errors++;
    if (s !== e) $display("MISMATCH %0t seen %h want %h", $time, s, e);
  endtask
  task cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // ready is judged at the falling edge, so the rising edge after it is the handshake
  task wb(input int k);
    do @(negedge aclk); while (k == 0 ? !s_axi_arready : k == 1 ? !s_axi_rvalid : !s_axi_bvalid);
    {rs, rd} = {s_axi_rresp, s_axi_rdata};
    @(posedge aclk);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {24'h0, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(negedge aclk);
      {x, y} = {s_axi_awready, s_axi_wready};
      @(posedge aclk);
      if (x) s_axi_awvalid <= 1'h0;
      if (y) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid & ~x) | (s_axi_wvalid & ~y));
    wb(2);
    s_axi_bready <= 1'h0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    wb(0);
    s_axi_arvalid <= 1'h0;
    wb(1);
    s_axi_rready <= 1'h0;
  endtask
  task cmd(input logic [16:0] c);
    axw(8'h00, {15'h0, c});
    do axr(8'h04); while (rd[0] !== 1'h0);
  endtask
  task up(input logic [3:0] m);
    @(posedge aclk) src_pins <= m;
    cyc(3);
    @(posedge aclk) src_pins <= 4'h0;
    cyc(2);
  endtask
  // ============
  // scenarios
  task hold;
    @(posedge aclk) src_pins <= 4'h1;
    cmd({1'h1, 8'h21, 8'h80});
    cmd({1'h0, 8'h21, 8'h00});
    chk(rd[15:8], 32'h80);
    cyc(350);
    @(posedge aclk) src_pins <= 4'h0;
    @(posedge aclk) src_pins <= 4'h1;
    cyc(350);
    chk(system_powered, 32'h1);
    cyc(250);
    chk(system_powered, 32'h0);
    @(posedge aclk) src_pins <= 4'h0;
    $display("hold done");
  endtask
  task wdog;
    up(4'h2);
    chk(system_powered, 32'h1);
    cmd({1'h1, 8'h20, 8'h03});
    cyc(350);
    cmd({1'h0, 8'h20, 8'h00});
    cyc(350);
    chk(system_powered, 32'h1);
    cyc(250);
    chk(system_powered, 32'h0);
    $display("watchdog done");
  endtask
  task wake;
    up(4'h8);
    chk(system_powered, 32'h1);
    cmd({1'h1, 8'h1c, 8'h04});
    cmd({1'h1, 8'h1a, 8'h00});
    repeat (2) cmd({1'h1, 8'h22, 8'h00});
    cmd({1'h1, 8'h22, 8'h02});
    cmd({1'h1, 8'h20, 8'h09});
    repeat (2)
    begin
      cyc(1);
      chk(system_powered, 32'h0);
      @(posedge aclk) rtc_second_tick <= 1'h1;
      @(posedge aclk) rtc_second_tick <= 1'h0;
    end
    cyc(2);
    chk(system_powered, 32'h1);
    cmd({1'h1, 8'h20, 8'h00});
    $display("wake done");
  endtask
  // pg open drain, reset strong push-pull; only heartbeat bit 0 keeps it alive
  task beat;
    up(4'h1);
    cmd({1'h1, 8'h1c, 8'h01});
    cmd({1'h1, 8'h1a, 8'h06});
    cyc(1);
    chk({power_good_output_out, power_good_output_oe, power_good_output_strong}, 32'h0);
    chk({system_reset_output_n_out, system_reset_output_oe, system_reset_output_strong}, 32'h7);
    cmd({1'h1, 8'h1c, 8'h04});
    cmd({1'h1, 8'h1a, 8'h04});
    cmd({1'h1, 8'h20, 8'h09});
    repeat (2)
    begin
      @(posedge aclk) heartbeat_input <= heartbeat_input ^ 3'h1;
      cyc(350);
    end
    chk(system_powered, 32'h1);
    @(posedge aclk) heartbeat_input <= 3'h2;
    cyc(250);
    chk(system_powered, 32'h0);
    chk({power_good_output_out, power_good_output_oe, power_good_output_strong}, 32'h2);
    chk({system_reset_output_n_out, system_reset_output_oe, system_reset_output_strong}, 32'h3);
    $display("heartbeat done");
  endtask
  task supply;
    up(4'h4);
    @(posedge aclk) junction_temp <= 8'h8b;
    cyc(5);
    chk(system_powered, 32'h1);
    @(posedge aclk) junction_temp <= 8'h8c;
    cyc(5);
    chk(system_powered, 32'h0);
    @(posedge aclk) junction_temp <= 8'h19;
    up(4'h4);
    @(posedge aclk) rail_low <= 5'h1;
    cyc(33500);
    chk(system_powered, 32'h1);
    cyc(1000);
    chk(system_reset_output_n_out, 32'h0);
    @(posedge aclk) rail_low <= 5'h0;
    cmd({1'h1, 8'h23, 8'h02});
    up(4'h4);
    @(posedge aclk) rail_low <= 5'h2;
    cyc(33500);
    chk(system_powered, 32'h1);
    cyc(1000);
    chk(system_powered, 32'h0);
    $display("supply done");
  endtask
  task conclude;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    cyc(5);
    @(posedge aclk) aresetn <= 1'h1;
    cyc(2);
    chk(system_reset_output_n_out, 32'h0);
    axr(8'h08);
    chk(rs, 32'h2);
    chk(rd, 32'h0);
    up(4'h1);
    chk(system_powered, 32'h1);
    chk(system_reset_output_n_out, 32'h1);
    cmd({1'h1, 8'h20, 8'h00});
    cyc(1);
    chk(system_powered, 32'h0);
    $display("basics done");
    hold;
    wdog;
    wake;
    beat;
    supply;
    conclude;
  end
  initial
  begin
    #1900000;
    n_errors++;
    conclude;
  end
endmodule
